// >>> common/ocs_pkg.sv
package ocs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_CONFIG = 4'h0;
  localparam logic [3:0] OFF_CONTROL = 4'h4;
  localparam logic [3:0] OFF_TRIM = 4'h8;
  localparam logic [3:0] OFF_STATUS = 4'hc;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_CORE_DIV_LSB = 4;
  localparam int CFG_PREDIV_LSB = 6;
  localparam int CFG_FEAT_LSB = 9;
  localparam int CTL_SYS_SEL_LSB = 0;
  localparam int CTL_FREQ_LSB = 4;
  localparam int TRIM_VALUE_LSB = 0;
  localparam int TRIM_SRC_BIT = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [1:0] CORE_DIV_RST = 2'h0;
  localparam logic [2:0] PREDIV_RST = 3'h0;
  localparam logic [3:0] FEAT_RST = 4'h0;
  localparam logic [1:0] SYS_SEL_RST = 2'h0;
  localparam logic [2:0] FREQ_RST = 3'h0;
  localparam logic [4:0] TRIM_VALUE_RST = 5'h00;
  localparam logic TRIM_SRC_RST = 1'b0;

  // ----------------------------------------------------------------
  // Oscillator mode codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_XT = 4'h0;
  localparam logic [3:0] MODE_STANDARD_MULTIPLIED_MODE = 4'h1;
  localparam logic [3:0] MODE_HS = 4'h2;
  localparam logic [3:0] MODE_HIGH_SPEED_MULTIPLIED_MODE = 4'h3;
  localparam logic [3:0] MODE_EC = 4'h4;
  localparam logic [3:0] MODE_EXTERNAL_CLOCK_PORT_PIN_MODE = 4'h5;
  localparam logic [3:0] MODE_EXTERNAL_CLOCK_MULTIPLIED_MODE = 4'h6;
  localparam logic [3:0] MODE_EXTERNAL_MULTIPLIED_PORT_PIN_MODE = 4'h7;
  localparam logic [3:0] MODE_INT_FAST_XTAL = 4'h8;
  localparam logic [3:0] MODE_INT_STD_XTAL = 4'h9;
  localparam logic [3:0] MODE_INT_PORT = 4'ha;
  localparam logic [3:0] MODE_INT_CLKOUT = 4'hb;

  // USB clock source codes.
  localparam logic [1:0] USB_SRC_STD_XTAL = 2'h0;
  localparam logic [1:0] USB_SRC_FAST_XTAL = 2'h1;
  localparam logic [1:0] USB_SRC_EXT_CLOCK = 2'h2;

  // Core clock branches.
  localparam logic [1:0] SEL_PRIMARY = 2'h0;
  localparam logic [1:0] SEL_MULT = 2'h1;
  localparam logic [1:0] SEL_FAST_POST = 2'h2;
  localparam logic [1:0] SEL_SLOW = 2'h3;

  // Divider terminal counts (ratio minus one).
  localparam logic [7:0] TERM_DIV256 = 8'hff;

endpackage

// >>> src/ocs_clock_select.sv
// Functional notes
// - Crystal modes divide the oscillator by 1, 2, 3 or 4 for the core clock.
// - External clock modes offer the same 1 to 4 core postscaler.
// - External clock and multiplied external modes drive the output pin with Fosc/4.
// - Port pin external modes turn the output pin into port A bit 6.
// - External clock modes need no oscillator start-up delay.
// - Multiplier runs only in the four multiplied modes.
// - Multiplier turns 4 MHz into a 96 MHz reference for USB and core.
// - Input prescaler with eight ratios up to 12 gives the 4 MHz multiplier input.
// - Core clock from the multiplier divides by 2, 3, 4 or 6.
// - Standard multiplied mode feeds an exact 4 MHz input straight to the multiplier.
// - Fast crystal mode may take an external clock; output pin left open.
// - Fast internal oscillator gives 8 MHz usable directly as device clock.
// - Fast oscillator postscaler gives device clocks from 31 kHz to 4 MHz.
// - Fast internal oscillator runs for selections from 125 kHz to 8 MHz, and for 31 kHz when the source bit is set.
// - Slow oscillator runs when selected or any timer feature needs it.
// - Internal frequency select bits choose fast direct, slow direct or postscaled fast.
// - With internal core clock, the internal mode chooses the USB clock source.
// - Internal modes pick fast crystal, standard crystal, clock with Fosc/4, or port pin.
// - Trim takes effect on the oscillators while instructions keep running.
// - No flag reports completion of a trim frequency shift.
// - Each trim step changes frequency by the same amount.
// - Low-frequency source bit picks the oscillator behind the 31 kHz option.
// - Source bit set gives fast oscillator divided by 256, clear gives slow oscillator.
// - Trim is 5-bit two's complement: 00000 centre, 01111 maximum, 10000 minimum.
module ocs_clock_select (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ocs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ocs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Oscillator edge pulses, one aclk cycle per source edge
  input wire logic crystal_input_pin_tick,
  input wire logic mult_ref_tick,
  input wire logic fast_osc_tick,
  input wire logic slow_osc_tick,
  // Output pin, shared with port A bit 6
  input wire logic crystal_output_pin_i,
  output logic crystal_output_pin_o,
  output logic crystal_output_pin_oe,
  input wire logic port_a_bit6_out,
  input wire logic port_a_bit6_drive,
  output logic port_a_bit6_in,
  // Clock tree control and results
  output logic core_clock_tick,
  output logic mult_in_tick,
  output logic mult_enable,
  output logic fast_osc_enable,
  output logic slow_osc_enable,
  output logic startup_delay_enable,
  output logic [1:0] usb_clock_source,
  output logic [4:0] trim_value_field
);

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  logic [31:0] cfg_q, ctl_q, trim_q;
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [ocs_pkg::ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] status_word;

  wire do_write = aw_hold_q && w_hold_q && !bvalid_q;
  wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire wr_cfg = do_write && (aw_addr_q == ocs_pkg::OFF_CONFIG);
  wire wr_ctl = do_write && (aw_addr_q == ocs_pkg::OFF_CONTROL);
  wire wr_trim = do_write && (aw_addr_q == ocs_pkg::OFF_TRIM);
  wire wr_ok = wr_cfg || wr_ctl || wr_trim || (aw_addr_q == ocs_pkg::OFF_STATUS);
  wire [31:0] cfg_new = (cfg_q & ~wmask) | (w_data_q & wmask);
  wire [31:0] ctl_new = (ctl_q & ~wmask) | (w_data_q & wmask);
  wire [31:0] trim_new = (trim_q & ~wmask) | (w_data_q & wmask);
  wire rd_take = s_axi_arvalid && !rvalid_q;
  wire rd_hit = (s_axi_araddr == ocs_pkg::OFF_CONFIG) || (s_axi_araddr == ocs_pkg::OFF_CONTROL)
    || (s_axi_araddr == ocs_pkg::OFF_TRIM) || (s_axi_araddr == ocs_pkg::OFF_STATUS);
  wire [31:0] rd_word = (s_axi_araddr == ocs_pkg::OFF_CONFIG) ? cfg_q :
    (s_axi_araddr == ocs_pkg::OFF_CONTROL) ? ctl_q :
    (s_axi_araddr == ocs_pkg::OFF_TRIM) ? trim_q :
    (s_axi_araddr == ocs_pkg::OFF_STATUS) ? status_word : 32'h0000_0000;

  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready = !w_hold_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bresp_q <= ocs_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_hold_q) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_hold_q) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_hold_q <= 1'b0;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? ocs_pkg::RESP_OKAY : ocs_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= ocs_pkg::RESP_OKAY;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? ocs_pkg::RESP_OKAY : ocs_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Only the documented fields are kept, so unused bits always read as zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= 32'h0000_0000;
      cfg_q[ocs_pkg::CFG_MODE_LSB +: 4] <= ocs_pkg::MODE_RST;
      cfg_q[ocs_pkg::CFG_CORE_DIV_LSB +: 2] <= ocs_pkg::CORE_DIV_RST;
      cfg_q[ocs_pkg::CFG_PREDIV_LSB +: 3] <= ocs_pkg::PREDIV_RST;
      cfg_q[ocs_pkg::CFG_FEAT_LSB +: 4] <= ocs_pkg::FEAT_RST;
      ctl_q <= 32'h0000_0000;
      ctl_q[ocs_pkg::CTL_SYS_SEL_LSB +: 2] <= ocs_pkg::SYS_SEL_RST;
      ctl_q[ocs_pkg::CTL_FREQ_LSB +: 3] <= ocs_pkg::FREQ_RST;
      trim_q <= 32'h0000_0000;
      trim_q[ocs_pkg::TRIM_VALUE_LSB +: 5] <= ocs_pkg::TRIM_VALUE_RST;
      trim_q[ocs_pkg::TRIM_SRC_BIT] <= ocs_pkg::TRIM_SRC_RST;
    end else begin
      if (wr_cfg) begin
        cfg_q <= 32'h0000_0000;
        cfg_q[ocs_pkg::CFG_MODE_LSB +: 4] <= cfg_new[ocs_pkg::CFG_MODE_LSB +: 4];
        cfg_q[ocs_pkg::CFG_CORE_DIV_LSB +: 2] <= cfg_new[ocs_pkg::CFG_CORE_DIV_LSB +: 2];
        cfg_q[ocs_pkg::CFG_PREDIV_LSB +: 3] <= cfg_new[ocs_pkg::CFG_PREDIV_LSB +: 3];
        cfg_q[ocs_pkg::CFG_FEAT_LSB +: 4] <= cfg_new[ocs_pkg::CFG_FEAT_LSB +: 4];
      end
      if (wr_ctl) begin
        ctl_q <= 32'h0000_0000;
        ctl_q[ocs_pkg::CTL_SYS_SEL_LSB +: 2] <= ctl_new[ocs_pkg::CTL_SYS_SEL_LSB +: 2];
        ctl_q[ocs_pkg::CTL_FREQ_LSB +: 3] <= ctl_new[ocs_pkg::CTL_FREQ_LSB +: 3];
      end
      if (wr_trim) begin
        trim_q <= 32'h0000_0000;
        trim_q[ocs_pkg::TRIM_VALUE_LSB +: 5] <= trim_new[ocs_pkg::TRIM_VALUE_LSB +: 5];
        trim_q[ocs_pkg::TRIM_SRC_BIT] <= trim_new[ocs_pkg::TRIM_SRC_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire [3:0] mode = cfg_q[ocs_pkg::CFG_MODE_LSB +: 4];
  wire [1:0] core_div = cfg_q[ocs_pkg::CFG_CORE_DIV_LSB +: 2];
  wire [2:0] prediv = cfg_q[ocs_pkg::CFG_PREDIV_LSB +: 3];
  wire [3:0] feat_en = cfg_q[ocs_pkg::CFG_FEAT_LSB +: 4];
  wire [2:0] freq_sel = ctl_q[ocs_pkg::CTL_FREQ_LSB +: 3];
  wire sys_internal = ctl_q[ocs_pkg::CTL_SYS_SEL_LSB + 1];
  wire low_freq_source_bit = trim_q[ocs_pkg::TRIM_SRC_BIT];

  wire mode_mult = (mode == ocs_pkg::MODE_HIGH_SPEED_MULTIPLIED_MODE) || (mode == ocs_pkg::MODE_STANDARD_MULTIPLIED_MODE)
    || (mode == ocs_pkg::MODE_EXTERNAL_CLOCK_MULTIPLIED_MODE) || (mode == ocs_pkg::MODE_EXTERNAL_MULTIPLIED_PORT_PIN_MODE);
  wire mode_ext = (mode == ocs_pkg::MODE_EC) || (mode == ocs_pkg::MODE_EXTERNAL_CLOCK_PORT_PIN_MODE)
    || (mode == ocs_pkg::MODE_EXTERNAL_CLOCK_MULTIPLIED_MODE) || (mode == ocs_pkg::MODE_EXTERNAL_MULTIPLIED_PORT_PIN_MODE);
  wire mode_int = (mode == ocs_pkg::MODE_INT_FAST_XTAL) || (mode == ocs_pkg::MODE_INT_STD_XTAL)
    || (mode == ocs_pkg::MODE_INT_PORT) || (mode == ocs_pkg::MODE_INT_CLKOUT);
  wire pin_fosc4 = (mode == ocs_pkg::MODE_EC) || (mode == ocs_pkg::MODE_EXTERNAL_CLOCK_MULTIPLIED_MODE)
    || (mode == ocs_pkg::MODE_INT_CLKOUT);
  wire pin_port = (mode == ocs_pkg::MODE_EXTERNAL_CLOCK_PORT_PIN_MODE) || (mode == ocs_pkg::MODE_EXTERNAL_MULTIPLIED_PORT_PIN_MODE)
    || (mode == ocs_pkg::MODE_INT_PORT);
  wire use_internal = mode_int || sys_internal;
  wire slow_direct = (freq_sel == 3'h0) && !low_freq_source_bit;
  wire [1:0] sel_target = use_internal ? (slow_direct ? ocs_pkg::SEL_SLOW : ocs_pkg::SEL_FAST_POST)
    : (mode_mult ? ocs_pkg::SEL_MULT : ocs_pkg::SEL_PRIMARY);
  wire [1:0] usb_src = (mode == ocs_pkg::MODE_XT || mode == ocs_pkg::MODE_STANDARD_MULTIPLIED_MODE
    || mode == ocs_pkg::MODE_INT_STD_XTAL) ? ocs_pkg::USB_SRC_STD_XTAL :
    (mode == ocs_pkg::MODE_HS || mode == ocs_pkg::MODE_HIGH_SPEED_MULTIPLIED_MODE
    || mode == ocs_pkg::MODE_INT_FAST_XTAL) ? ocs_pkg::USB_SRC_FAST_XTAL
    : ocs_pkg::USB_SRC_EXT_CLOCK;

  // ----------------------------------------------------------------
  // Ratio tables, held as terminal counts
  // ----------------------------------------------------------------
  function automatic logic [7:0] prediv_term(input logic [2:0] code);
    case (code)
      3'h0: prediv_term = 8'h00;
      3'h1: prediv_term = 8'h01;
      3'h2: prediv_term = 8'h02;
      3'h3: prediv_term = 8'h03;
      3'h4: prediv_term = 8'h04;
      3'h5: prediv_term = 8'h05;
      3'h6: prediv_term = 8'h09;
      3'h7: prediv_term = 8'h0b;
      default: prediv_term = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] mult_post_term(input logic [1:0] code);
    case (code)
      2'h0: mult_post_term = 8'h01;
      2'h1: mult_post_term = 8'h02;
      2'h2: mult_post_term = 8'h03;
      2'h3: mult_post_term = 8'h05;
      default: mult_post_term = 8'h01;
    endcase
  endfunction

  // Code 000 only reaches this divider when the fast source backs it.
  function automatic logic [7:0] fast_post_term(input logic [2:0] code);
    case (code)
      3'h7: fast_post_term = 8'h00;
      3'h6: fast_post_term = 8'h01;
      3'h5: fast_post_term = 8'h03;
      3'h4: fast_post_term = 8'h07;
      3'h3: fast_post_term = 8'h0f;
      3'h2: fast_post_term = 8'h1f;
      3'h1: fast_post_term = 8'h3f;
      default: fast_post_term = ocs_pkg::TERM_DIV256;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Dividers: 0 prescaler, 1 multiplier postscaler, 2 primary, 3 fast
  // ----------------------------------------------------------------
  wire [3:0] div_in;
  wire [7:0] term_d [4];
  logic [3:0] div_tick_q;
  logic [7:0] term_q [4];

  assign div_in = {fast_osc_tick, crystal_input_pin_tick, mult_ref_tick, crystal_input_pin_tick};
  assign term_d[0] = (mode == ocs_pkg::MODE_STANDARD_MULTIPLIED_MODE) ? 8'h00 : prediv_term(prediv);
  assign term_d[1] = mult_post_term(core_div);
  assign term_d[2] = {6'h00, core_div};
  assign term_d[3] = fast_post_term(freq_sel);

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_div
      logic [7:0] cnt_q;
      // A new ratio is taken only at a period boundary, so no short pulse is cut.
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cnt_q <= 8'h00;
          term_q[gi] <= 8'h00;
          div_tick_q[gi] <= 1'b0;
        end else begin
          div_tick_q[gi] <= div_in[gi] && (cnt_q >= term_q[gi]);
          if (div_in[gi]) begin
            if (cnt_q >= term_q[gi]) begin
              cnt_q <= 8'h00;
              term_q[gi] <= term_d[gi];
            end else begin
              cnt_q <= cnt_q + 8'h01;
            end
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Core clock branch select
  // ----------------------------------------------------------------
  logic [1:0] sel_q;
  logic core_tick_q;
  wire [3:0] branch_tick = {slow_osc_tick, div_tick_q[3], div_tick_q[1], div_tick_q[2]};
  wire [3:0] branch_live = {1'b1, 1'b1, mode_mult, 1'b1};
  // A branch that stopped can hand over at once; otherwise wait for its edge.
  wire sel_go = (sel_q != sel_target) && (branch_tick[sel_q] || !branch_live[sel_q]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_q <= ocs_pkg::SEL_PRIMARY;
      core_tick_q <= 1'b0;
    end else begin
      core_tick_q <= branch_tick[sel_q];
      if (sel_go) begin
        sel_q <= sel_target;
      end
    end
  end

  // ----------------------------------------------------------------
  // Oscillator enables and pin
  // ----------------------------------------------------------------
  logic mult_en_q, fast_en_q, slow_en_q, startup_q;
  logic [1:0] usb_src_q, fosc_cnt_q;
  logic pin_o_q, pin_oe_q, port_in_q;
  logic [4:0] trim_out_q;

  wire fast_need = (sel_target == ocs_pkg::SEL_FAST_POST) || (sel_q == ocs_pkg::SEL_FAST_POST);
  wire slow_need = (sel_target == ocs_pkg::SEL_SLOW) || (sel_q == ocs_pkg::SEL_SLOW)
    || (feat_en != 4'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mult_en_q <= 1'b0;
      fast_en_q <= 1'b0;
      slow_en_q <= 1'b0;
      startup_q <= 1'b1;
      usb_src_q <= ocs_pkg::USB_SRC_STD_XTAL;
      fosc_cnt_q <= 2'h0;
      pin_o_q <= 1'b0;
      pin_oe_q <= 1'b0;
      port_in_q <= 1'b0;
      trim_out_q <= ocs_pkg::TRIM_VALUE_RST;
    end else begin
      mult_en_q <= mode_mult;
      fast_en_q <= fast_need;
      slow_en_q <= slow_need;
      startup_q <= !mode_ext && !(mode == ocs_pkg::MODE_INT_PORT)
        && !(mode == ocs_pkg::MODE_INT_CLKOUT);
      usb_src_q <= usb_src;
      if (core_tick_q) begin
        fosc_cnt_q <= fosc_cnt_q + 2'h1;
      end
      // Crystal modes leave the pin to the amplifier; in fast crystal mode it stays open.
      pin_o_q <= pin_port ? port_a_bit6_out : (pin_fosc4 && fosc_cnt_q[1]);
      pin_oe_q <= pin_port ? port_a_bit6_drive : pin_fosc4;
      port_in_q <= pin_port ? crystal_output_pin_i : 1'b0;
      // Trim goes straight to the oscillators with no settle flag or stall.
      trim_out_q <= trim_q[ocs_pkg::TRIM_VALUE_LSB +: 5];
    end
  end

  assign status_word = {20'h00000, usb_src_q, sel_q, 4'h0, startup_q, slow_en_q, fast_en_q,
    mult_en_q};
  assign core_clock_tick = core_tick_q;
  assign mult_in_tick = div_tick_q[0] && mult_en_q;
  assign mult_enable = mult_en_q;
  assign fast_osc_enable = fast_en_q;
  assign slow_osc_enable = slow_en_q;
  assign startup_delay_enable = startup_q;
  assign usb_clock_source = usb_src_q;
  assign crystal_output_pin_o = pin_o_q;
  assign crystal_output_pin_oe = pin_oe_q;
  assign port_a_bit6_in = port_in_q;
  assign trim_value_field = trim_out_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_mult_mode_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 mult_enable == $past(mode_mult))
    else $error("multiplier enable disagrees with mode");

  a_ext_no_startup: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 $past(mode_ext) |-> !startup_delay_enable)
    else $error("start-up delay in external clock mode");

  a_port_pin_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_port && $stable(mode) |=> crystal_output_pin_oe == $past(port_a_bit6_drive))
    else $error("port pin enable does not follow port");

  a_fosc4_pin_rate: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_fosc4 && $stable(mode) && !$stable(fosc_cnt_q[1]) |=> $past(crystal_output_pin_oe)
      && crystal_output_pin_o == $past(fosc_cnt_q[1]))
    else $error("clock out pin not Fosc/4");

  a_hs_pin_open: assert property (@(posedge aclk) disable iff (!aresetn)
    mode == ocs_pkg::MODE_HS ##1 mode == ocs_pkg::MODE_HS |-> !crystal_output_pin_oe)
    else $error("output pin driven in fast crystal mode");

  a_standard_multiplied_mode_no_prediv: assert property (@(posedge aclk) disable iff (!aresetn)
    mode == ocs_pkg::MODE_STANDARD_MULTIPLIED_MODE && crystal_input_pin_tick && g_div[0].cnt_q >= term_q[0]
      |=> term_q[0] == 8'h00 ##0 div_tick_q[0])
    else $error("prescaler active in standard multiplied mode");

  a_fast_osc_off: assert property (@(posedge aclk) disable iff (!aresetn)
    use_internal && slow_direct && sel_q == ocs_pkg::SEL_SLOW |=> !fast_osc_enable)
    else $error("fast oscillator runs on slow selection");

  a_slow_osc_feat: assert property (@(posedge aclk) disable iff (!aresetn)
    feat_en != 4'h0 |=> slow_osc_enable)
    else $error("slow oscillator off while a timer feature needs it");

  a_sel_boundary: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 !$stable(sel_q) |-> $past(branch_tick[sel_q] || !branch_live[sel_q]))
    else $error("core branch changed mid-period");

endmodule

// >>> tb/ocs_osc_source.sv
module ocs_osc_source #(
  parameter int XTAL_P = 3,
  parameter int SLOW_P = 5
) (
  // Clock and enables from the block
  input wire logic aclk,
  input wire logic mult_enable,
  input wire logic fast_osc_enable,
  input wire logic slow_osc_enable,
  // Oscillator edge pulses
  output logic crystal_input_pin_tick,
  output logic mult_ref_tick,
  output logic fast_osc_tick,
  output logic slow_osc_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  int xc = 0;
  int sc = 0;
  // A stopped oscillator gives no edges, so a wrong enable shows up as a dead clock.
  always @(posedge aclk) begin
    xc <= (xc + 1) % XTAL_P;
    sc <= (sc + 1) % SLOW_P;
    crystal_input_pin_tick <= (xc == 0);
    mult_ref_tick <= mult_enable;
    fast_osc_tick <= fast_osc_enable;
    slow_osc_tick <= slow_osc_enable && (sc == 0);
  end
endmodule

// >>> tb/ocs_clock_select_tb_top.sv
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module ocs_clock_select_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic port_a_bit6_out = 1'b1, port_a_bit6_drive = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, usb_clock_source, rsp, sel = 2'h0;
  logic crystal_input_pin_tick, mult_ref_tick, fast_osc_tick, slow_osc_tick, pin_q = 1'b0;
  logic crystal_output_pin_o, crystal_output_pin_oe, port_a_bit6_in, core_clock_tick;
  logic mult_in_tick, mult_enable, fast_osc_enable, slow_osc_enable, startup_delay_enable;
  logic [4:0] trim_value_field;
  int fail_count = 0, tests_run = 0, cyc = 0;
  int pre_r[8] = '{1, 2, 3, 4, 5, 6, 10, 12};
  int post_r[4] = '{2, 3, 4, 6};
  // The pin has a board pull-up, so a released pin reads high.
  wire crystal_output_pin_i = crystal_output_pin_oe ? crystal_output_pin_o : 1'b1;
  wire msig = (sel == 2'h0) ? core_clock_tick : (sel == 2'h1) ? mult_in_tick :
              (crystal_output_pin_o & ~pin_q);
  ocs_osc_source src (.*);
  ocs_clock_select uut (.*);
  initial forever #4 aclk = ~aclk;
  always @(posedge aclk) begin
    pin_q <= crystal_output_pin_o;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // Bus and measurement tasks
  // ----------------------------------------------------------------
  task close_out();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task axi(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    logic ah, wh, bh, arh, rh;
    n = 0;
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
    {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    do begin
      @(negedge aclk);
      n++;
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bready && s_axi_bvalid;
      arh = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rready && s_axi_rvalid;
      if (bh) rsp = s_axi_bresp;
      if (rh) {rsp, rd} = {s_axi_rresp, s_axi_rdata};
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (bh) s_axi_bready <= 1'b0;
      if (arh) s_axi_arvalid <= 1'b0;
      if (rh) s_axi_rready <= 1'b0;
    end while ((s_axi_awvalid || s_axi_wvalid || s_axi_bready || s_axi_arvalid ||
                s_axi_rready) && n < 200);
    if (n >= 200) fail_count++;
    repeat (3) @(negedge aclk);
  endtask
  task cfg(input logic [3:0] m, input logic [1:0] dv, input logic [2:0] pv, input logic [3:0] f);
    axi(1'b1, ocs_pkg::OFF_CONFIG, 32'(m) | (32'(dv) << ocs_pkg::CFG_CORE_DIV_LSB) |
        (32'(pv) << ocs_pkg::CFG_PREDIV_LSB) | (32'(f) << ocs_pkg::CFG_FEAT_LSB));
  endtask
  // Uses the second gap between pulses (before the third pulse), so the ratio in force before a change is skipped.
  task per(input logic [1:0] s, input int e);
    int c, k, g;
    {c, k, g} = {32'sd0, 32'sd0, 32'sd0};
    sel = s;
    for (int i = 0; i < 3000 && k < 3; i++) begin
      @(negedge aclk);
      c++;
      if (msig) {k, g, c} = {k + 1, c, 32'sd0};
    end
    `CHK(g, e)
  endtask
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(negedge aclk);
    `CHK(startup_delay_enable, 1'b1)
    for (int m = 0; m < 8; m++) begin
      cfg(4'(m), 2'h0, 3'h0, 4'h0);
      `CHK(mult_enable, 1'(m inside {1, 3, 6, 7}))
      `CHK(startup_delay_enable, 1'(m < 4))
      `CHK(slow_osc_enable, 1'b0)
      if (m >= 4) `CHK(crystal_output_pin_oe, 1'b1)
    end
    @(posedge aclk);
    port_a_bit6_drive <= 1'b0;
    port_a_bit6_out <= 1'b0;
    cfg(ocs_pkg::MODE_EXTERNAL_CLOCK_PORT_PIN_MODE, 2'h0, 3'h0, 4'h0);
    `CHK({crystal_output_pin_oe, crystal_output_pin_o, port_a_bit6_in}, 3'b001)
    cfg(ocs_pkg::MODE_HS, 2'h0, 3'h0, 4'h0);
    `CHK(crystal_output_pin_oe, 1'b0)
    for (int d = 0; d < 4; d++) begin
      cfg(ocs_pkg::MODE_XT, 2'(d), 3'h0, 4'h0);
      per(2'h0, 3 * (d + 1));
      cfg(ocs_pkg::MODE_EC, 2'(d), 3'h0, 4'h0);
      per(2'h0, 3 * (d + 1));
      cfg(ocs_pkg::MODE_EXTERNAL_CLOCK_MULTIPLIED_MODE, 2'(d), 3'h0, 4'h0);
      per(2'h0, post_r[d]);
      cfg(ocs_pkg::MODE_EC, 2'h0, 3'h0, 4'(1 << d));
      `CHK(slow_osc_enable, 1'b1)
    end
    cfg(ocs_pkg::MODE_EC, 2'h1, 3'h0, 4'h0);
    per(2'h2, 24);
    for (int p = 0; p < 8; p++) begin
      cfg(ocs_pkg::MODE_HIGH_SPEED_MULTIPLIED_MODE, 2'h0, 3'(p), 4'h0);
      per(2'h1, 3 * pre_r[p]);
    end
    cfg(ocs_pkg::MODE_STANDARD_MULTIPLIED_MODE, 2'h0, 3'h7, 4'h0);
    per(2'h1, 3);
    for (int m = 8; m < 12; m++) begin
      cfg(4'(m), 2'h0, 3'h0, 4'h0);
      `CHK(usb_clock_source, (m == 8) ? 2'h1 : (m == 9) ? 2'h0 : 2'h2)
    end
    for (int f = 7; f > 0; f--) begin
      axi(1'b1, ocs_pkg::OFF_CONTROL, (32'(f) << ocs_pkg::CTL_FREQ_LSB) | 32'h2);
      per(2'h0, 1 << (7 - f));
      `CHK(fast_osc_enable, 1'b1)
    end
    axi(1'b1, ocs_pkg::OFF_CONTROL, 32'h2);
    per(2'h0, 5);
    `CHK({fast_osc_enable, slow_osc_enable}, 2'b01)
    axi(1'b1, ocs_pkg::OFF_TRIM, 32'hff);
    per(2'h0, 256);
    `CHK(trim_value_field, 5'h1f)
    axi(1'b0, ocs_pkg::OFF_TRIM, 32'h0);
    `CHK(rd, 32'h9f)
    axi(1'b0, ocs_pkg::OFF_STATUS, 32'h0);
    `CHK(rd[31:12], 20'h0)
    axi(1'b0, 4'h6, 32'h0);
    `CHK(rsp, ocs_pkg::RESP_SLVERR)
    close_out();
  end
endmodule
